//--- common/psm_regs.vh
// register offsets, field positions, reset values and timing counts of the power-saving control
`ifndef PSM_REGS_VH
`define PSM_REGS_VH

`define PSM_ADDR_CTRL      4'h0
`define PSM_ADDR_STATUS    4'h4
`define PSM_ADDR_CPUREG    4'h8
`define PSM_ADDR_PORTLAT   4'hc

`define PSM_BIT_IDLE_ARM   0
`define PSM_BIT_PD_ARM     1
`define PSM_BIT_GF0        2
`define PSM_BIT_GF1        3
`define PSM_BIT_SLOW       4
`define PSM_BIT_IDLE_START 5
`define PSM_BIT_PD_START   6
`define PSM_BIT_SMOD       7

`define PSM_CTRL_RESET     8'h00
`define PSM_SLOW_DIV       8
`define PSM_MACHINE_CYCLE  12
`define PSM_SLOW_SYNC_MAX  2
`define PSM_RESET_CYCLES   2

`endif

//--- hw/psm_power_ctrl.v
// power-saving mode control: idle, slow-down and power-down with axi4-lite registers
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`include "psm_regs.vh"

module psm_power_ctrl (
    input  wire        clk,                   // system oscillator clock, 100 mhz
    input  wire        srst,                  // synchronous reset, active high
    input  wire [3:0]  s_axi_awaddr,          // write address
    input  wire        s_axi_awvalid,         // write address valid
    output reg         s_axi_awready,         // write address ready
    input  wire [31:0] s_axi_wdata,           // write data
    input  wire [3:0]  s_axi_wstrb,           // write byte strobes
    input  wire        s_axi_wvalid,          // write data valid
    output reg         s_axi_wready,          // write data ready
    output reg  [1:0]  s_axi_bresp,           // write response
    output reg         s_axi_bvalid,          // write response valid
    input  wire        s_axi_bready,          // write response ready
    input  wire [3:0]  s_axi_araddr,          // read address
    input  wire        s_axi_arvalid,         // read address valid
    output reg         s_axi_arready,         // read address ready
    output reg  [31:0] s_axi_rdata,           // read data
    output reg  [1:0]  s_axi_rresp,           // read response
    output reg         s_axi_rvalid,          // read data valid
    input  wire        s_axi_rready,          // read data ready
    input  wire        instr_done,            // cpu completes an instruction, pulse
    input  wire        irq_pending,           // an enabled interrupt is requested
    input  wire        power_save_permit_pin, // pin: high blocks idle and power-down entry
    input  wire [7:0]  port_in,               // port input pins
    input  wire [7:0]  alt_out,               // alternate-function outputs
    input  wire [7:0]  alt_en,                // alternate function active per bit
    input  wire [7:0]  bus_ale,               // normal address latch strobe (bit 0)
    input  wire        bus_fetch,             // normal program fetch strobe
    output reg         cpu_clk_en,            // cpu clock enable pulse
    output reg         periph_clk_en,         // peripheral clock enable pulse
    output reg         wdt_clk_en,            // watchdog clock enable pulse
    output reg         osc_run,               // oscillators running
    output reg         idle_q,                // idle mode active
    output reg         pdown_q,               // power-down mode active
    output reg         ale_out,               // address latch strobe pin
    output reg         program_fetch_strobe,  // program fetch strobe pin
    output reg  [7:0]  port_out,              // port output pins
    output reg  [7:0]  port_sync              // synchronised port inputs
);

////////////////////////////////////////////////////////////////////////////////
// permit pin and port input synchronisers

reg [2:0] permit_sync_q;
reg       permit_q;
reg [7:0] port_s1_q;
reg [7:0] port_s2_q;
reg [7:0] port_s3_q;

// resets to blocked: entry is refused until the pin has been seen low
always @(posedge clk) begin
    if (srst) begin
        permit_sync_q <= 3'h7;
        permit_q      <= 1'b1;
    end else begin
        permit_sync_q <= {permit_sync_q[1:0], power_save_permit_pin};
        // accept a new level only once the last two stages agree
        if (permit_sync_q[1] == permit_sync_q[2])
            permit_q <= permit_sync_q[2];
    end
end

always @(posedge clk) begin
    if (srst) begin
        port_s1_q <= 8'h00;
        port_s2_q <= 8'h00;
        port_s3_q <= 8'h00;
    end else begin
        port_s1_q <= port_in;
        port_s2_q <= port_s1_q;
        port_s3_q <= port_s2_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// shared decoding

// true when one bit of a control byte is set and its partner bit is clear
function lone_bit;
    input [7:0] wr_byte;
    input integer set_pos;
    input integer clr_pos;
    begin
        lone_bit = wr_byte[set_pos] && !wr_byte[clr_pos];
    end
endfunction

// per-bit choice: sel high takes alt, sel low takes lat
function [7:0] port_mux;
    input [7:0] lat;
    input [7:0] alt;
    input [7:0] sel;
    begin
        port_mux = (lat & ~sel) | (alt & sel);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel

// response codes shared by both channels
localparam [1:0] RESP_OKAY   = 2'h0;
localparam [1:0] RESP_SLVERR = 2'h2;

// address and data are taken independently; the response follows both
reg [3:0]  awaddr_q;
reg        aw_have_q;
reg [31:0] wdata_q;
reg [3:0]  wstrb_q;
reg        w_have_q;
wire       wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

always @(posedge clk) begin
    if (srst) begin
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        awaddr_q      <= 4'h0;
        wdata_q       <= 32'h00000000;
        wstrb_q       <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= 2'h0;
    end else begin
        s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
        s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == `PSM_ADDR_CTRL ||
                             awaddr_q == `PSM_ADDR_PORTLAT) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// control and latch writes act on the edge the response is raised
wire       ctrl_wr = wr_go && awaddr_q == `PSM_ADDR_CTRL && wstrb_q[0];
wire       lat_wr  = wr_go && awaddr_q == `PSM_ADDR_PORTLAT && wstrb_q[0];
wire [7:0] wbyte   = wdata_q[7:0];

////////////////////////////////////////////////////////////////////////////////
// entry sequencer: arm then start in the following instruction

reg       idle_arm_q;
reg       pd_arm_q;
reg       arm_age_q;
reg       slow_q;
reg [1:0] gf_q;
reg       smod_q;
reg [7:0] latch_q;
reg [7:0] alt_hold_q;

wire try_idle = ctrl_wr && lone_bit(wbyte, `PSM_BIT_IDLE_START, `PSM_BIT_IDLE_ARM)
              && idle_arm_q && !permit_q;
wire try_pd   = ctrl_wr && lone_bit(wbyte, `PSM_BIT_PD_START, `PSM_BIT_PD_ARM)
              && pd_arm_q && !permit_q;

always @(posedge clk) begin
    if (srst) begin
        idle_arm_q <= 1'b0;
        pd_arm_q   <= 1'b0;
        arm_age_q  <= 1'b0;
        slow_q     <= 1'b0;
        gf_q       <= 2'h0;
        smod_q     <= 1'b0;
        idle_q     <= 1'b0;
        pdown_q    <= 1'b0;
        latch_q    <= 8'hff;
        alt_hold_q <= 8'h00;
    end else begin
        if (lat_wr && !pdown_q)
            latch_q <= wbyte;
        if (ctrl_wr) begin
            slow_q <= wbyte[`PSM_BIT_SLOW];
            gf_q   <= {wbyte[`PSM_BIT_GF1], wbyte[`PSM_BIT_GF0]};
            smod_q <= wbyte[`PSM_BIT_SMOD];
            // arm only when written alone with its start bit clear
            idle_arm_q <= lone_bit(wbyte, `PSM_BIT_IDLE_ARM, `PSM_BIT_IDLE_START);
            pd_arm_q   <= lone_bit(wbyte, `PSM_BIT_PD_ARM, `PSM_BIT_PD_START);
            arm_age_q  <= 1'b0;
        end else if (instr_done) begin
            // the arming write's own instruction ends first, then the next one
            arm_age_q <= 1'b1;
            if (arm_age_q) begin
                idle_arm_q <= 1'b0;
                pd_arm_q   <= 1'b0;
            end
        end
        // power-down takes precedence over a simultaneous idle start
        if (try_pd) begin
            pdown_q    <= 1'b1;
            alt_hold_q <= alt_out;
        end else if (try_idle && !pdown_q) begin
            idle_q <= 1'b1;
        end else if (idle_q && irq_pending) begin
            // wake-up returns the cpu clock; slow mode is untouched
            idle_q <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// clock enables: slow-down prescaler

reg [2:0] slow_cnt_q;
reg       slow_act_q;
wire      slow_switch;

// entering slow waits for the prescaler wrap so no enable is cut short;
// leaving is immediate
// the prescaler runs at full rate too, so a slow request sees a wrap within eight cycles
assign slow_switch = (slow_q != slow_act_q) && (slow_cnt_q == 3'h7 || !slow_q);

always @(posedge clk) begin
    if (srst) begin
        slow_cnt_q <= 3'h0;
        slow_act_q <= 1'b0;
    end else if (!pdown_q) begin
        slow_cnt_q <= slow_cnt_q + 3'h1;
        if (slow_switch)
            slow_act_q <= slow_q;
    end
end

wire base_tick = !slow_act_q || slow_cnt_q == 3'h7;
// nothing runs in power-down, or from the edge its start write is taken
wire run_any   = !pdown_q && !try_pd;
// cpu and watchdog stop in idle and from the edge the idle start is taken
wire run_cpu   = run_any && !idle_q && !try_idle;

always @(posedge clk) begin
    if (srst) begin
        cpu_clk_en    <= 1'b0;
        periph_clk_en <= 1'b0;
        wdt_clk_en    <= 1'b0;
        osc_run       <= 1'b1;
    end else begin
        osc_run       <= run_any;
        periph_clk_en <= base_tick && run_any;
        // watchdog follows the cpu enable: it is the one peripheral idle stops
        wdt_clk_en    <= base_tick && run_cpu;
        cpu_clk_en    <= base_tick && run_cpu;
    end
end

////////////////////////////////////////////////////////////////////////////////
// bus strobes and port pins

// outside the power modes the strobes follow the bus one cycle late
always @(posedge clk) begin
    if (srst) begin
        ale_out              <= 1'b1;
        program_fetch_strobe <= 1'b1;
    end else if (pdown_q) begin
        ale_out              <= 1'b0;
        program_fetch_strobe <= 1'b0;
    end else if (idle_q) begin
        ale_out              <= 1'b1;
        program_fetch_strobe <= 1'b1;
    end else begin
        ale_out              <= bus_ale[0];
        program_fetch_strobe <= bus_fetch;
    end
end

// alternate outputs freeze at power-down entry; latch-driven bits keep the latch
always @(posedge clk) begin
    if (srst)
        port_out <= 8'hff;
    else if (pdown_q)
        port_out <= port_mux(latch_q, alt_hold_q, alt_en);
    else
        port_out <= port_mux(latch_q, alt_out, alt_en);
end

// an input bit moves only once the last two stages agree; frozen in power-down
wire [7:0] port_agree = ~(port_s2_q ^ port_s3_q);

always @(posedge clk) begin
    if (srst)
        port_sync <= 8'h00;
    else if (!pdown_q)
        port_sync <= port_mux(port_sync, port_s3_q, port_agree);
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel

// arm bits are held only internally and start bits are never stored, so both read back as zero
reg [7:0] ctrl_rd;
// status word: live mode and clock state for software
wire [4:0] status_bits = {permit_q, slow_act_q, pdown_q, idle_q, osc_run};

always @* begin
    ctrl_rd = 8'h00;
    ctrl_rd[`PSM_BIT_SLOW] = slow_q;
    ctrl_rd[`PSM_BIT_GF0]  = gf_q[0];
    ctrl_rd[`PSM_BIT_GF1]  = gf_q[1];
    ctrl_rd[`PSM_BIT_SMOD] = smod_q;
end

always @(posedge clk) begin
    if (srst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= 2'h0;
    end else begin
        // one read outstanding: arready is withheld while rvalid stands
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                `PSM_ADDR_CTRL:    s_axi_rdata <= {24'h000000, ctrl_rd};
                `PSM_ADDR_STATUS:  s_axi_rdata <= {27'h0000000, status_bits};
                `PSM_ADDR_PORTLAT: s_axi_rdata <= {24'h000000, latch_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // psm_power_ctrl

//--- testbench/psm_power_ctrl_chk.sv
// concurrent checks on the power-saving control ports
module psm_power_ctrl_chk (
    input logic clk,                  // clock
    input logic srst,                 // sync reset
    input logic irq_pending,          // wake request
    input logic cpu_clk_en,           // cpu enable
    input logic periph_clk_en,        // peripheral enable
    input logic wdt_clk_en,           // watchdog enable
    input logic osc_run,              // oscillators running
    input logic idle_q,               // idle flag
    input logic pdown_q,              // power-down flag
    input logic ale_out,              // latch strobe pin
    input logic program_fetch_strobe  // fetch strobe pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_idle_gate; idle_q |-> !cpu_clk_en && !wdt_clk_en; endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("enable in idle");
    property p_idle_per; idle_q |-> ##[0:8] (periph_clk_en || !idle_q); endproperty
    a_idle_per: assert property (p_idle_per) else $error("peripherals stopped");
    property p_idle_pin; idle_q && $past(idle_q) |-> ale_out && program_fetch_strobe; endproperty
    a_idle_pin: assert property (p_idle_pin) else $error("strobes low in idle");
    property p_pd_pin; pdown_q && $past(pdown_q) |-> !ale_out && !program_fetch_strobe;
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("strobes high in pd");
    property p_pd_osc; pdown_q && $past(pdown_q) |-> !osc_run && !periph_clk_en; endproperty
    a_pd_osc: assert property (p_pd_osc) else $error("clocks in pd");
    property p_pd_hold; pdown_q |=> pdown_q; endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("pd left");
    property p_wake; idle_q && irq_pending |-> ##[1:9] !idle_q; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_excl; !(idle_q && pdown_q); endproperty
    a_excl: assert property (p_excl) else $error("both modes");
endmodule // psm_power_ctrl_chk

bind psm_power_ctrl psm_power_ctrl_chk psm_power_ctrl_chk_i (
    .clk(clk), .srst(srst), .irq_pending(irq_pending), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .wdt_clk_en(wdt_clk_en), .osc_run(osc_run),
    .idle_q(idle_q), .pdown_q(pdown_q), .ale_out(ale_out),
    .program_fetch_strobe(program_fetch_strobe));

//--- testbench/psm_cpu_model.sv
// cpu-side stand-in: instruction completion pulses and bus strobes
module psm_cpu_model #(parameter int INSTR_CYCLES = 8) (
    input  logic       clk,        // clock
    input  logic       srst,       // sync reset
    output logic       instr_done, // one pulse per instruction
    output logic [7:0] bus_ale,    // latch strobe, bit 0
    output logic       bus_fetch   // fetch strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    always @(posedge clk) begin
        if (srst) cnt_q <= 4'h0;
        else cnt_q <= (cnt_q == 4'(INSTR_CYCLES - 1)) ? 4'h0 : cnt_q + 4'h1;
    end
    // each pulse closes one instruction, bounding the arm window
    assign instr_done = (cnt_q == 4'(INSTR_CYCLES - 1));
    assign bus_ale = {7'h00, cnt_q[0]};
    assign bus_fetch = cnt_q[1];
endmodule // psm_cpu_model

//--- testbench/tb.sv
// self-checking bench for the power-saving control
`include "psm_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, irq = 0, permit = 0;
    logic [3:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata;
    logic awr, wr_, bv, arr, rv, idone, bfetch, cpu_en, per_en, wdt_en, osc, idle, pdn, ale, pfs;
    logic [1:0] bresp, rresp;
    logic [7:0] bale, pout, psync;
    logic [7:0] alt = 8'h3c, pin = 8'h5a;
    int bad_count = 0, check_count = 0, cycles = 0, k;
    psm_cpu_model psm_cpu_model_i (.clk(clk), .srst(srst), .instr_done(idone), .bus_ale(bale),
        .bus_fetch(bfetch));
    psm_power_ctrl psm_power_ctrl_i (.clk(clk), .srst(srst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .instr_done(idone), .irq_pending(irq), .power_save_permit_pin(permit),
        .port_in(pin), .alt_out(alt), .alt_en(8'h0f), .bus_ale(bale), .bus_fetch(bfetch),
        .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .wdt_clk_en(wdt_en), .osc_run(osc),
        .idle_q(idle), .pdown_q(pdn), .ale_out(ale), .program_fetch_strobe(pfs),
        .port_out(pout), .port_sync(psync));
    initial forever #5 clk = ~clk;
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report;
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_ === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        br <= 1'b0;
        chk("bresp", {30'h0, bresp}, 32'h0);
    endtask
    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rr <= 1'b0;
        chk(nm, rdata, e);
        chk({nm, " resp"}, {30'h0, rresp}, {30'h0, er});
    endtask
    task automatic seq(input logic [7:0] a1, a2);
        wr(`PSM_ADDR_CTRL, a1);
        wr(`PSM_ADDR_CTRL, a2);
        cyc(4);
    endtask
    task automatic cnt(input int n);
        k = 0;
        repeat (n) begin
            @(posedge clk);
            k += (cpu_en === 1'b1);
        end
    endtask
    task automatic t_reset;
        rchk("ctrl", `PSM_ADDR_CTRL, 32'h0, 2'h0);
        rchk("unmapped", 4'h8, 32'h0, 2'h2);
        rchk("status", `PSM_ADDR_STATUS, 32'h1, 2'h0);
        chk("port in", psync, 8'h5a);
        wr(`PSM_ADDR_PORTLAT, 8'h55);
        rchk("latch", `PSM_ADDR_PORTLAT, 32'h55, 2'h0);
        chk("port out", pout, 8'h5c);
        $display("test reset done");
    endtask
    task automatic t_idle;
        seq(8'h01, 8'h20);
        chk("idle", idle, 1);
        chk("cpu en", cpu_en, 0);
        chk("strobes", {ale, pfs}, 2'b11);
        chk("idle port", pout, 8'h5c);
        pin <= 8'ha5;
        cyc(6);
        chk("idle input", psync, 8'ha5);
        rchk("ctrl idle", `PSM_ADDR_CTRL, 32'h0, 2'h0);
        irq <= 1'b1;
        cyc(4);
        chk("wake", idle, 0);
        irq <= 1'b0;
        $display("test idle done");
    endtask
    task automatic t_refuse;
        wr(`PSM_ADDR_CTRL, 8'h21);
        cyc(12);
        chk("same write", idle, 0);
        wr(`PSM_ADDR_CTRL, 8'h01);
        cyc(24);
        wr(`PSM_ADDR_CTRL, 8'h20);
        cyc(4);
        chk("late start", idle, 0);
        permit <= 1'b1;
        cyc(6);
        seq(8'h01, 8'h20);
        chk("permit idle", idle, 0);
        seq(8'h02, 8'h40);
        chk("permit pd", pdn, 0);
        permit <= 1'b0;
        cyc(6);
        $display("test refuse done");
    endtask
    task automatic t_slow;
        wr(`PSM_ADDR_CTRL, 8'h10);
        cyc(16);
        cnt(64);
        chk("slow rate", k, `PSM_SLOW_DIV);
        seq(8'h11, 8'h30);
        chk("idle slow", idle, 1);
        irq <= 1'b1;
        cyc(10);
        chk("wake slow", idle, 0);
        irq <= 1'b0;
        rchk("slow kept", `PSM_ADDR_CTRL, 32'h10, 2'h0);
        wr(`PSM_ADDR_CTRL, 8'h00);
        cyc(2);
        cnt(16);
        chk("full rate", k, 16);
        $display("test slow done");
    endtask
    task automatic t_pd;
        seq(8'h03, 8'h60);
        chk("pd", {idle, pdn, osc}, 3'b010);
        chk("pd strobes", {ale, pfs}, 2'b00);
        alt <= 8'h03;
        cyc(3);
        chk("pd alt hold", pout, 8'h5c);
        irq <= 1'b1;
        cyc(20);
        chk("pd kept", pdn, 1);
        irq <= 1'b0;
        srst <= 1'b1;
        cyc(2);
        srst <= 1'b0;
        cyc(4);
        chk("pd exit", {pdn, osc}, 2'b01);
        rchk("ctrl after", `PSM_ADDR_CTRL, 32'h0, 2'h0);
        chk("port reset", pout, 8'hf3);
        $display("test power-down done");
    endtask
    initial begin
        cyc(5);
        srst <= 1'b0;
        cyc(4);
        t_reset;
        t_idle;
        t_refuse;
        t_slow;
        t_pd;
        final_report;
    end
endmodule // tb
